// >>> odc_cfg.svh
// Constants for the display command decoder: command codes, reset values and timing.
`ifndef ODC_CFG_SVH
`define ODC_CFG_SVH

// ****************************************
// Command codes
// ****************************************
`define ODC_CMD_PANEL_OFF 8'hAE
`define ODC_CMD_PANEL_ON 8'hAF
`define ODC_CMD_ROW_SET 8'hB0
`define ODC_CMD_SCAN_HI 4'hC
`define ODC_CMD_OFFSET 8'hD3
`define ODC_CMD_CLOCK 8'hD5
`define ODC_CMD_PERIOD 8'hD9
`define ODC_CMD_PADS 8'hDA
`define ODC_CMD_DESELECT 8'hDB
`define ODC_CMD_VSL_HI 4'h3
`define ODC_CMD_RMW 8'hE0
`define ODC_CMD_RMW_END 8'hEE

// ****************************************
// Field positions
// ****************************************
`define ODC_SCAN_BIT 3
`define ODC_PADS_BIT 4
`define ODC_ON_BIT 0

// ****************************************
// Reset values and limits
// ****************************************
`define ODC_RST_DIVIDE 4'h0
`define ODC_RST_TRIM 4'h5
`define ODC_RST_PERIOD 4'h2
`define ODC_RST_DESELECT 8'h35
`define ODC_RST_VSL 4'h0
`define ODC_RST_ROW 6'h00
`define ODC_RST_OFFSET 6'h00
`define ODC_COL_LIMIT 8'h80
`define ODC_DESELECT_UNITY 8'h40

// ****************************************
// Timing
// ****************************************
`define ODC_CLK_PERIOD_NS 10
`define ODC_BUSY_RST_NS 200
`define ODC_BUSY_RST_CYC ((`ODC_BUSY_RST_NS + `ODC_CLK_PERIOD_NS - 1) / `ODC_CLK_PERIOD_NS)
`define ODC_LINE_TICKS 6'h3F

`endif

// >>> odc_pkg.sv
// Types shared by the display command decoder and its display tick generator.
`default_nettype none
package odc_pkg;

  typedef enum logic [2:0] {
    ODC_ST_IDLE,
    ODC_ST_ROW,
    ODC_ST_OFFSET,
    ODC_ST_CLOCK,
    ODC_ST_PERIOD,
    ODC_ST_PADS,
    ODC_ST_DESELECT
  } odc_state_type;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmd_data_select;
    logic [7:0] data;
  } odc_pins_type;

  typedef struct packed {
    logic [5:0] offset;
    logic [3:0] divide;
    logic [3:0] osc_trim;
    logic [3:0] precharge;
    logic [3:0] discharge;
    logic com_interleave;
    logic [7:0] deselect_code;
    logic deselect_unity;
    logic [3:0] segment_discharge_level;
    logic scan_reverse_req;
  } odc_settings_type;

  typedef struct packed {
    logic osc_run;
    logic converter_run;
    logic drive_on;
    logic high_impedance;
  } odc_power_type;

  typedef struct packed {
    logic [3:0] div_cnt;
    logic [5:0] tick_cnt;
    logic display_tick;
    logic line_start;
  } odc_tick_type;

endpackage
`default_nettype wire

// >>> odc_tick_gen.sv
// Display tick divider and scan line timer for the display command decoder.
`default_nettype none
`include "odc_cfg.svh"
module odc_tick_gen
  import odc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [3:0] i_divide,
  output logic o_display_tick,
  output logic o_line_start
);

  odc_tick_type r_q;
  odc_tick_type r_d;

  // ****************************************
  // Divider
  // ****************************************
  // The reference clock stands in for the oscillator; the divider holds while asleep (i_run low).
  always_comb
  begin
    r_d = r_q;
    r_d.display_tick = 1'b0;
    r_d.line_start = 1'b0;
    if (i_run)
    begin
      if (r_q.div_cnt >= i_divide)
      begin
        r_d.div_cnt = 4'h0;
        r_d.display_tick = 1'b1;
        if (r_q.tick_cnt == `ODC_LINE_TICKS)
        begin
          r_d.tick_cnt = 6'h00;
          r_d.line_start = 1'b1;
        end
        else
        begin
          r_d.tick_cnt = r_q.tick_cnt + 6'h01;
        end
      end
      else
      begin
        r_d.div_cnt = r_q.div_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_display_tick = r_q.display_tick;
  assign o_line_start = r_q.line_start;

endmodule
`default_nettype wire

// >>> odc_decoder.sv
// Command decoder for the display driver: host port, settings, pointers and sleep.
//
// Operation
// (RQ1) AEH turns the panel off, AFH on; bit 0 picks on; off after reset.
// (RQ2) Executing panel off puts the device into sleep.
// (RQ3) Sleep stops oscillator, converter and drive; segment and common outputs float.
// (RQ4) Sleep keeps frame memory and settings, and host memory access still works.
// (RQ5) B0H then a byte loads row pointer from its low six bits; display unaffected.
// (RQ6) C0H to C8H bit 3 picks scan direction, taken at the next scan line.
// (RQ7) D3H then a byte sets vertical offset 0 to 63, reset zero.
// (RQ8) D5H byte low nibble plus one divides oscillator into display ticks.
// (RQ9) D5H byte high nibble trims oscillator, code 0101 nominal at reset.
// (RQ10) D9H byte holds precharge and discharge lengths, both 2 after reset.
// (RQ11) Low nibble sets precharge 1 to 15 ticks; zero is invalid.
// (RQ12) High nibble sets discharge 1 to 15 ticks; zero is invalid.
// (RQ13) DAH byte bit 4 picks interleaved (set, reset) or sequential common pads.
// (RQ14) DBH byte is the deselect level code, 40H and up is unity, reset 35H.
// (RQ15) 30H to 3FH set segment discharge level code from the low nibble.
// (RQ16) E0H saves column; reads then hold the column, writes still advance it.
// (RQ17) EEH leaves read-modify-write and restores the saved column.
// (RQ18) The host always closes read-modify-write with the end command.
// (RQ19) A data write stores at row and column, then advances the column.
// (RQ20) Status read gives busy on bit 7, panel off on bit 6, low bits zero.
// (RQ21) Commands are rejected while busy; the host polls busy or waits.
// (RQ22) Data read returns current byte and advances; host does one dummy read.
// (RQ23) No frame memory read path while the serial interface is selected.
// (RQ24) Column advances per access, stopping at 128, row pointer untouched.
// (RQ25) After a double-byte mode byte, the next command byte is its parameter.
`default_nettype none
`include "odc_cfg.svh"
module odc_decoder
  import odc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_rd_n,
  input wire logic i_cmd_data_select,
  input wire logic i_serial_mode,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_busy,
  output logic o_panel_on,
  output odc_power_type o_power,
  output odc_settings_type o_settings,
  output logic o_scan_reverse,
  output logic o_display_tick,
  output logic o_line_start,
  output logic [12:0] o_mem_addr,
  output logic [7:0] o_mem_wdata,
  output logic o_mem_we,
  output logic o_mem_re,
  input wire logic [7:0] i_mem_rdata
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    odc_pins_type s1;
    odc_pins_type s2;
    odc_pins_type s3;
    logic serial1;
    logic serial2;
    odc_state_type st;
    odc_settings_type set;
    logic panel_on;
    odc_power_type power;
    logic scan_reverse;
    logic [5:0] row;
    logic [7:0] col;
    logic [7:0] col_saved;
    logic rmw;
    logic [7:0] rd_data;
    logic data_oe;
    logic [7:0] latch;
    logic pend;
    logic [7:0] busy_cnt;
    logic busy;
    logic mem_we;
    logic mem_re;
    logic [12:0] mem_addr;
    logic [7:0] mem_wdata;
  } odc_core_type;

  odc_core_type r_q;
  odc_core_type r_d;
  logic wr_edge;
  logic rd_edge;
  logic cmd_wr;
  logic dat_wr;
  logic st_rd;
  logic dat_rd;
  logic [7:0] byte_in;
  logic tick_line;

  odc_tick_gen u_tick (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(r_q.power.osc_run),
    .i_divide(r_q.set.divide),
    .o_display_tick(o_display_tick),
    .o_line_start(tick_line)
  );

  // ****************************************
  // Host strobes
  // ****************************************
  // Only the second and third stages are looked at; the first is the metastable one.
  assign wr_edge = r_q.s2.wr_n & ~r_q.s3.wr_n & ~r_q.s3.cs_n;
  assign rd_edge = ~r_q.s2.rd_n & r_q.s3.rd_n & ~r_q.s2.cs_n;
  assign byte_in = r_q.s3.data;
  assign cmd_wr = wr_edge & ~r_q.s3.cmd_data_select & ~r_q.busy; // see RQ21
  assign dat_wr = wr_edge & r_q.s3.cmd_data_select & ~r_q.busy; // see RQ21
  assign st_rd = rd_edge & ~r_q.s2.cmd_data_select;
  assign dat_rd = rd_edge & r_q.s2.cmd_data_select & ~r_q.serial2 & ~r_q.busy; // see RQ23

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    r_d = r_q;
    r_d.s1 = {i_cs_n, i_wr_n, i_rd_n, i_cmd_data_select, i_data};
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.serial1 = i_serial_mode;
    r_d.serial2 = r_q.serial1;
    r_d.mem_we = 1'b0;
    r_d.mem_re = 1'b0;
    r_d.pend = 1'b0;
    r_d.data_oe = ~r_q.s2.rd_n & ~r_q.s2.cs_n;
    if (r_q.busy_cnt != 8'h00)
    begin
      r_d.busy_cnt = r_q.busy_cnt - 8'h01;
    end
    if (r_q.pend)
    begin
      r_d.latch = i_mem_rdata;
    end
    if (tick_line)
    begin
      r_d.scan_reverse = r_q.set.scan_reverse_req; // see RQ6
    end
    if (cmd_wr)
    begin
      unique case (r_q.st)
        ODC_ST_IDLE:
        begin
          if (byte_in[7:1] == 7'(`ODC_CMD_PANEL_OFF >> 1))
          begin
            r_d.panel_on = byte_in[`ODC_ON_BIT]; // see RQ1
          end
          else if (byte_in == `ODC_CMD_ROW_SET)
          begin
            r_d.st = ODC_ST_ROW; // see RQ25
          end
          else if (byte_in[7:4] == `ODC_CMD_SCAN_HI)
          begin
            r_d.set.scan_reverse_req = byte_in[`ODC_SCAN_BIT]; // see RQ6
          end
          else if (byte_in == `ODC_CMD_OFFSET)
          begin
            r_d.st = ODC_ST_OFFSET;
          end
          else if (byte_in == `ODC_CMD_CLOCK)
          begin
            r_d.st = ODC_ST_CLOCK;
          end
          else if (byte_in == `ODC_CMD_PERIOD)
          begin
            r_d.st = ODC_ST_PERIOD;
          end
          else if (byte_in == `ODC_CMD_PADS)
          begin
            r_d.st = ODC_ST_PADS;
          end
          else if (byte_in == `ODC_CMD_DESELECT)
          begin
            r_d.st = ODC_ST_DESELECT;
          end
          else if (byte_in[7:4] == `ODC_CMD_VSL_HI)
          begin
            r_d.set.segment_discharge_level = byte_in[3:0]; // see RQ15
          end
          else if (byte_in == `ODC_CMD_RMW)
          begin
            r_d.rmw = 1'b1; // see RQ16
            r_d.col_saved = r_q.col;
          end
          else if (byte_in == `ODC_CMD_RMW_END)
          begin
            r_d.rmw = 1'b0; // see RQ17
            r_d.col = r_q.col_saved;
          end
        end
        ODC_ST_ROW:
        begin
          r_d.row = byte_in[5:0]; // see RQ5
          r_d.st = ODC_ST_IDLE;
        end
        ODC_ST_OFFSET:
        begin
          r_d.set.offset = byte_in[5:0]; // see RQ7
          r_d.st = ODC_ST_IDLE;
        end
        ODC_ST_CLOCK:
        begin
          r_d.set.divide = byte_in[3:0]; // see RQ8
          r_d.set.osc_trim = byte_in[7:4]; // see RQ9
          r_d.st = ODC_ST_IDLE;
        end
        ODC_ST_PERIOD:
        begin
          if (byte_in[3:0] != 4'h0)
          begin
            r_d.set.precharge = byte_in[3:0]; // see RQ10, RQ11
          end
          if (byte_in[7:4] != 4'h0)
          begin
            r_d.set.discharge = byte_in[7:4]; // see RQ10, RQ12
          end
          r_d.st = ODC_ST_IDLE;
        end
        ODC_ST_PADS:
        begin
          r_d.set.com_interleave = byte_in[`ODC_PADS_BIT]; // see RQ13
          r_d.st = ODC_ST_IDLE;
        end
        ODC_ST_DESELECT:
        begin
          r_d.set.deselect_code = byte_in; // see RQ14
          r_d.set.deselect_unity = (byte_in >= `ODC_DESELECT_UNITY);
          r_d.st = ODC_ST_IDLE;
        end
        default:
        begin
          r_d.st = ODC_ST_IDLE;
        end
      endcase
    end
    // Memory accesses go on while asleep; the column stops at its limit.
    if (dat_wr)
    begin
      r_d.mem_we = (r_q.col != `ODC_COL_LIMIT); // see RQ4, RQ19
      r_d.mem_addr = {r_q.row, r_q.col[6:0]};
      r_d.mem_wdata = byte_in;
      if (r_q.col != `ODC_COL_LIMIT)
      begin
        r_d.col = r_q.col + 8'h01; // see RQ24
      end
    end
    if (st_rd)
    begin
      r_d.rd_data = {r_q.busy, ~r_q.panel_on, 6'h00}; // see RQ20
    end
    // A read hands out the byte fetched by the previous read, hence the dummy read.
    if (dat_rd)
    begin
      r_d.rd_data = r_q.latch; // see RQ22
      r_d.mem_re = 1'b1;
      r_d.mem_addr = {r_q.row, r_q.col[6:0]};
      r_d.pend = 1'b1;
      if (!r_q.rmw && r_q.col != `ODC_COL_LIMIT)
      begin
        r_d.col = r_q.col + 8'h01; // see RQ16, RQ24
      end
    end
    r_d.power.osc_run = r_d.panel_on; // see RQ2, RQ3
    r_d.power.converter_run = r_d.panel_on;
    r_d.power.drive_on = r_d.panel_on;
    r_d.power.high_impedance = ~r_d.panel_on;
    r_d.busy = (r_d.busy_cnt != 8'h00) | r_d.pend; // see RQ21
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      r_q <= '0;
      r_q.s1 <= '1;
      r_q.s2 <= '1;
      r_q.s3 <= '1;
      r_q.st <= ODC_ST_IDLE;
      r_q.set.divide <= `ODC_RST_DIVIDE;
      r_q.set.osc_trim <= `ODC_RST_TRIM;
      r_q.set.precharge <= `ODC_RST_PERIOD;
      r_q.set.discharge <= `ODC_RST_PERIOD;
      r_q.set.com_interleave <= 1'b1;
      r_q.set.deselect_code <= `ODC_RST_DESELECT;
      r_q.set.segment_discharge_level <= `ODC_RST_VSL;
      r_q.set.offset <= `ODC_RST_OFFSET;
      r_q.row <= `ODC_RST_ROW;
      r_q.power.high_impedance <= 1'b1;
      r_q.busy_cnt <= 8'(`ODC_BUSY_RST_CYC);
      r_q.busy <= 1'b1;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_data = r_q.rd_data;
  assign o_data_oe = r_q.data_oe;
  assign o_busy = r_q.busy;
  assign o_panel_on = r_q.panel_on;
  assign o_power = r_q.power;
  assign o_settings = r_q.set;
  assign o_scan_reverse = r_q.scan_reverse;
  assign o_line_start = tick_line;
  assign o_mem_addr = r_q.mem_addr;
  assign o_mem_wdata = r_q.mem_wdata;
  assign o_mem_we = r_q.mem_we;
  assign o_mem_re = r_q.mem_re;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_panel_on_cmd: assert property ( // see RQ1
    (cmd_wr && r_q.st == ODC_ST_IDLE && byte_in[7:1] == 7'h57)
      |=> (r_q.panel_on == $past(byte_in[0])))
    else $error("Panel state does not follow on/off command.");
  a_sleep_float: assert property ( // see RQ3
    !r_q.panel_on |-> (r_q.power.high_impedance && !r_q.power.osc_run && !r_q.power.drive_on))
    else $error("Sleep does not stop drive and float outputs.");
  a_row_param: assert property ( // see RQ5
    (cmd_wr && r_q.st == ODC_ST_ROW) |=> (r_q.row == $past(byte_in[5:0]) && r_q.st == ODC_ST_IDLE))
    else $error("Row pointer not loaded from parameter byte.");
  a_period_keep: assert property ( // see RQ11
    (cmd_wr && r_q.st == ODC_ST_PERIOD && byte_in[3:0] == 4'h0) |=> $stable(r_q.set.precharge))
    else $error("Invalid precharge code was stored.");
  a_rmw_restore: assert property ( // see RQ17
    (cmd_wr && r_q.st == ODC_ST_IDLE && byte_in == 8'hEE) |=> (r_q.col == $past(r_q.col_saved)))
    else $error("End command did not restore the column.");
  a_rmw_read_hold: assert property ( // see RQ16
    (dat_rd && r_q.rmw) |=> $stable(r_q.col))
    else $error("Column advanced on read in read-modify-write.");
  a_write_advance: assert property ( // see RQ19
    (dat_wr && r_q.col < 8'h80) |=> (r_q.mem_we && r_q.col == $past(r_q.col) + 8'h01))
    else $error("Data write did not store and advance.");
  a_status_bits: assert property ( // see RQ20
    st_rd |=> (r_q.rd_data[7] == $past(r_q.busy) && r_q.rd_data[6] == !$past(r_q.panel_on)
      && r_q.rd_data[2:0] == 3'h0))
    else $error("Status byte layout wrong.");
  a_busy_reject: assert property ( // see RQ21
    (wr_edge && r_q.busy) |=> ($stable(r_q.set) && $stable(r_q.panel_on) && !r_q.mem_we))
    else $error("Write taken while busy.");
  a_serial_no_read: assert property ( // see RQ23
    (rd_edge && r_q.serial2) |=> !r_q.mem_re)
    else $error("Memory read in serial mode.");
  a_read_fetch: assert property ( // see RQ22
    dat_rd |=> r_q.mem_re ##1 (r_q.latch == $past(i_mem_rdata)))
    else $error("Read fetch did not land in the latch.");

  c_panel_on: cover property (cmd_wr && byte_in == 8'hAF);
  c_rmw_cycle: cover property (r_q.rmw ##[1:200] !r_q.rmw);
  c_double_byte: cover property (cmd_wr && r_q.st == ODC_ST_CLOCK);
  c_scan_flip: cover property (tick_line && r_q.set.scan_reverse_req);

endmodule
`default_nettype wire

// >>> odc_frame_mem.sv
// Frame memory model on the far side of the decoder's memory port.
`default_nettype none
module odc_frame_mem
(
  input wire logic i_ref_clk,
  input wire logic [12:0] i_mem_addr,
  input wire logic [7:0] i_mem_wdata,
  input wire logic i_mem_we,
  input wire logic i_mem_re,
  output logic [7:0] o_mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [8192];
  logic [7:0] junk = 8'hA5;
  // Every location starts as its own low address byte, so unwritten reads are known.
  initial
  begin
    foreach (mem[i])
      mem[i] = 8'(i);
  end
  always @(posedge i_ref_clk)
  begin
    if (i_mem_we)
      mem[i_mem_addr] <= i_mem_wdata;
    junk <= ~junk;
  end
  // Read data stands only while the read strobe is high; otherwise the bus toggles.
  assign o_mem_rdata = i_mem_re ? mem[i_mem_addr] : junk;
endmodule
`default_nettype wire

// >>> tb_oled_display_command_decoder.sv
// Self-checking testbench for the display command decoder.
`default_nettype none
module tb_oled_display_command_decoder
  import odc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] prm;
    logic two;
    logic [3:0] k;
    logic [7:0] exp;
  } odc_row_type;
  localparam odc_row_type ROWS [16] = '{
    '{8'hD3, 8'hC5, 1'b1, 4'h0, 8'h05}, '{8'hD3, 8'h3F, 1'b1, 4'h0, 8'h3F},
    '{8'hD5, 8'h3A, 1'b1, 4'h1, 8'h0A}, '{8'hD5, 8'hF0, 1'b1, 4'h2, 8'h0F},
    '{8'hD9, 8'h5F, 1'b1, 4'h3, 8'h0F}, '{8'hD9, 8'h5F, 1'b1, 4'h4, 8'h05},
    '{8'hD9, 8'h07, 1'b1, 4'h4, 8'h05}, '{8'hD9, 8'h70, 1'b1, 4'h3, 8'h07},
    '{8'hDA, 8'h02, 1'b1, 4'h5, 8'h00}, '{8'hDA, 8'h12, 1'b1, 4'h5, 8'h01},
    '{8'hDB, 8'h40, 1'b1, 4'h7, 8'h01}, '{8'hDB, 8'h3F, 1'b1, 4'h6, 8'h3F},
    '{8'h3A, 8'h00, 1'b0, 4'h8, 8'h0A}, '{8'h30, 8'h00, 1'b0, 4'h8, 8'h00},
    '{8'hC8, 8'h00, 1'b0, 4'h9, 8'h01}, '{8'hC7, 8'h00, 1'b0, 4'h9, 8'h00}};
  localparam odc_settings_type RST_SET = '{6'h00, 4'h0, 4'h5, 4'h2, 4'h2, 1'b1, 8'h35, 1'b0,
    4'h0, 1'b0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n = 1'b1;
  logic wr_n = 1'b1;
  logic rd_n = 1'b1;
  logic dcs = 1'b0;
  logic ser = 1'b0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, mrd, mwd, v;
  logic oe, busy, pon, scan_rev, tick, lstart, mwe, mre;
  odc_power_type power;
  odc_settings_type settings;
  logic [12:0] maddr, wa, ra, ra0;
  int failures = 0;
  int n_checks = 0;
  int nwe = 0;
  int nre = 0;
  int n, k;
  odc_decoder DUT (.i_ref_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_wr_n(wr_n),
    .i_rd_n(rd_n), .i_cmd_data_select(dcs), .i_serial_mode(ser), .i_data(din), .o_data(dout),
    .o_data_oe(oe), .o_busy(busy), .o_panel_on(pon), .o_power(power), .o_settings(settings),
    .o_scan_reverse(scan_rev), .o_display_tick(tick), .o_line_start(lstart),
    .o_mem_addr(maddr), .o_mem_wdata(mwd), .o_mem_we(mwe), .o_mem_re(mre), .i_mem_rdata(mrd));
  odc_frame_mem u_mem (.i_ref_clk(clk), .i_mem_addr(maddr), .i_mem_wdata(mwd),
    .i_mem_we(mwe), .i_mem_re(mre), .o_mem_rdata(mrd));
  always #5 clk = ~clk;
  // Strobes are sampled on the falling edge, clear of the edge that launches them.
  always @(negedge clk)
  begin
    if (mwe)
    begin
      nwe++;
      wa = maddr;
    end
    if (mre)
    begin
      nre++;
      ra = maddr;
    end
  end
  task automatic chk(input string what, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic a0, input logic [7:0] b);
    @(posedge clk);
    din <= b;
    dcs <= a0;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (3) @(posedge clk);
    wr_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    din <= ~b;
    repeat (4) @(posedge clk);
  endtask
  task automatic rd(input logic a0, output logic [7:0] q);
    @(posedge clk);
    dcs <= a0;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (5) @(posedge clk);
    q = dout;
    chk("data drive", oe, 1'b1);
    rd_n <= 1'b1;
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("data release", oe, 1'b0);
  endtask
  function automatic logic [7:0] fld(input odc_settings_type s, input logic [3:0] i);
    case (i)
      4'h0: return {2'h0, s.offset};
      4'h1: return {4'h0, s.divide};
      4'h2: return {4'h0, s.osc_trim};
      4'h3: return {4'h0, s.precharge};
      4'h4: return {4'h0, s.discharge};
      4'h5: return {7'h00, s.com_interleave};
      4'h6: return s.deselect_code;
      4'h7: return {7'h00, s.deselect_unity};
      4'h8: return {4'h0, s.segment_discharge_level};
      default: return {7'h00, s.scan_reverse_req};
    endcase
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("settings", settings, RST_SET);
    chk("power", power, 4'h1);
    chk("busy", busy, 1'b1);
  endtask
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
  initial
  begin
    do_reset();
    wr(1'b0, 8'hAF);
    rd(1'b0, v);
    chk("status busy", v, 8'hC0);
    n = 0;
    while (busy && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk("refused on", pon, 1'b0);
    rd(1'b0, v);
    chk("status idle", v, 8'h40);
    $display("test reset done");
    foreach (ROWS[i])
    begin
      wr(1'b0, ROWS[i].cmd);
      if (ROWS[i].two)
        wr(1'b0, ROWS[i].prm);
      chk("field", fld(settings, ROWS[i].k), ROWS[i].exp);
    end
    $display("test table done");
    wr(1'b0, 8'hD5);
    wr(1'b0, 8'h03);
    wr(1'b0, 8'hAF);
    chk("power on", {pon, power}, 5'h1E);
    n = 0;
    while (!tick && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    n = 1;
    while (!tick && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    chk("tick gap", n, 4);
    n = 0;
    while (!lstart && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    k = 0;
    n = 0;
    do
    begin
      @(negedge clk);
      k += tick;
      n++;
    end
    while (!lstart && n < 600);
    chk("ticks per line", k, 64);
    wr(1'b0, 8'hC8);
    n = 0;
    while (!scan_rev && n < 600)
    begin
      @(negedge clk);
      n++;
    end
    chk("scan reverse", scan_rev, 1'b1);
    wr(1'b0, 8'hAE);
    chk("sleep", {pon, power}, 5'h01);
    k = 0;
    repeat (50)
    begin
      @(negedge clk);
      k += tick;
    end
    chk("ticks in sleep", k, 0);
    chk("divide kept", settings.divide, 4'h3);
    $display("test power done");
    wr(1'b0, 8'hB0);
    wr(1'b0, 8'hAF);
    chk("param not cmd", pon, 1'b0);
    wr(1'b0, 8'hB0);
    wr(1'b0, 8'h45);
    wr(1'b0, 8'hE0);
    wr(1'b1, 8'h11);
    wr(1'b1, 8'h22);
    wr(1'b1, 8'h33);
    chk("write addr", {wa, mwd}, {6'h05, 7'h02, 8'h33});
    wr(1'b0, 8'hEE);
    rd(1'b1, v);
    rd(1'b1, v);
    chk("read first", v, 8'h11);
    rd(1'b1, v);
    chk("read second", {ra, v}, {6'h05, 7'h02, 8'h22});
    wr(1'b0, 8'hE0);
    rd(1'b1, v);
    ra0 = ra;
    rd(1'b1, v);
    chk("rmw hold", {ra, v}, {ra0, 8'h83});
    wr(1'b0, 8'hEE);
    $display("test memory done");
    n = nre;
    ser <= 1'b1;
    rd(1'b1, v);
    chk("serial read", {n[7:0], dout, v}, {nre[7:0], 8'h83, 8'h83});
    rd(1'b1, k[7:0]);
    chk("serial no fetch", nre, n);
    ser <= 1'b0;
    n = nwe;
    repeat (130) wr(1'b1, 8'h5A);
    chk("column stop", {nwe - n, wa}, {32'd125, 6'h05, 7'h7F});
    $display("test column done");
    do_reset();
    chk("reset scan", {pon, scan_rev}, 2'b00);
    $display("test second reset done");
    end_sim();
  end
endmodule
`default_nettype wire
